// ### tsc_pkg.sv
// Purpose: Shared constants and carriers for the per-timeslot signaling and receive channel control block.
// Assumes: Register indices are word indices; the byte address is four times the index.
// Notes:   One framer channel of 24 timeslots.
package tsc_pkg;

	// ============================================================
	// Register map (indices)
	localparam logic [9:0] TSC_TX_SIG_FIRST  = 10'h340;
	localparam logic [9:0] TSC_TX_SIG_LAST   = 10'h357;
	localparam logic [9:0] TSC_RX_CHAN_FIRST = 10'h360;
	localparam logic [9:0] TSC_RX_CHAN_LAST  = 10'h377;
	localparam logic [9:0] TSC_TX_IF_CTRL    = 10'h120;
	localparam logic [9:0] TSC_RX_SIG_LINK   = 10'h10C;
	localparam int         TSC_SLOTS         = 24;

	// ============================================================
	// Reset values
	localparam logic [7:0] TSC_TX_RST_SLOT0  = 8'h01;
	localparam logic [7:0] TSC_TX_RST_SLOT16 = 8'hB3;
	localparam logic [7:0] TSC_TX_RST_OTHER  = 8'hD0;
	localparam logic [7:0] TSC_RX_RST        = 8'h00;
	localparam logic [7:0] TSC_CTRL_RST      = 8'h00;

	// ============================================================
	// Field positions
	localparam int TSC_SIG_A_POS     = 7;
	localparam int TSC_ROB_EN_POS    = 2;
	localparam int TSC_SRC_LSB       = 0;
	localparam int TSC_LINK_SEL_LSB  = 6;
	localparam int TSC_ZERO_SEL_LSB  = 4;
	localparam int TSC_IF_EN_POS     = 0;
	localparam int TSC_DE_SRC_LSB    = 0;

	// ============================================================
	// Field encodings
	localparam logic [1:0] TSC_SRC_REG   = 2'h1;
	localparam logic [1:0] TSC_SRC_PIN   = 2'h2;
	localparam logic [1:0] TSC_LINK_C1   = 2'h0;
	localparam logic [1:0] TSC_LINK_C2   = 2'h1;
	localparam logic [1:0] TSC_LINK_ALT  = 2'h2;
	localparam logic [1:0] TSC_LINK_C3   = 2'h3;
	localparam logic [1:0] TSC_ZS_NONE   = 2'h0;
	localparam logic [1:0] TSC_ZS_BIT7   = 2'h1;
	localparam logic [1:0] TSC_ZS_B8B7   = 2'h2;
	localparam logic [1:0] TSC_ZS_DDS    = 2'h3;
	localparam logic [7:0] TSC_DDS_CODE  = 8'h98;
	localparam logic [7:0] TSC_BIT7_MASK = 8'h02;
	localparam logic [7:0] TSC_BIT8_MASK = 8'h01;
	localparam logic [1:0] TSC_RESP_OK   = 2'h0;
	localparam logic [1:0] TSC_RESP_ERR  = 2'h2;

	// ============================================================
	// Carriers
	typedef struct packed {
		logic       valid;
		logic [4:0] slot;
		logic       sig_frame;
		logic [1:0] sig_phase;
		logic [7:0] octet;
	} tsc_tx_in_t;

	typedef struct packed {
		logic       valid;
		logic [7:0] octet;
	} tsc_tx_out_t;

	typedef struct packed {
		logic       valid;
		logic [4:0] slot;
		logic       sig_frame;
		logic       sig_bit;
		logic [7:0] octet;
	} tsc_rx_in_t;

	typedef struct packed {
		logic       valid;
		logic [7:0] octet;
		logic [2:0] ctrl_sel;
		logic       alt_src;
		logic [1:0] de_src;
	} tsc_rx_out_t;

endpackage : tsc_pkg

// ### tsc_slot_reg.sv
// Purpose: One byte-wide software register with a fixed reset value.
// Assumes: Write enable already qualified by address and byte strobe.
// Notes:   Instantiated once per timeslot register.
module tsc_slot_reg #(
	parameter logic [7:0] RST_VAL = 8'h00
) (
	input  wire logic       core_clk, // Block clock.
	input  wire logic       arst_n,   // Asynchronous reset, active low.
	input  wire logic       wr_en,    // Write this register.
	input  wire logic [7:0] wr_data,  // Byte to store.
	output logic      [7:0] value     // Stored byte.
);

	logic [7:0] next_value;

	always_comb
	begin
		next_value = wr_en ? wr_data : value;
	end

	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
			value <= RST_VAL;
		else
			value <= next_value;
	end

endmodule : tsc_slot_reg

// ### tsc_sig_ctrl.sv
// Purpose: Per-timeslot transmit signaling source and receive channel control with an AXI4-Lite slave.
// Assumes: Octets arrive already parallel with their slot number; the signaling pin is asynchronous.
// Notes:   Each datapath has one cycle of latency; bus answers follow one cycle after the request is complete.
import tsc_pkg::*;

// Operation
// R1: Source 00 or 11 keeps PCM signaling.
// R2: Source 01 inserts register signaling bits.
// R3: Source 10 uses pin when interface enabled.
// R4: Transmit registers reset to 01, B3, D0.
// R5: 24 transmit registers at 0x340 to 0x357.
// R6: Link select routes to controllers 1,2,3.
// R7: Link select 10 defers to D/E source.
// R8: 24 receive registers at 0x360, reset zero.
// R9: Suppression 00 leaves octet alone.
// R10: Suppression 01 stuffs bit 7.
// R11: Suppression 10 stuffs bit 8 or 7.
// R12: Suppression 11 substitutes octet 0x98.
// R13: Robbed bit replaces the eighth bit.
// R14: Register signaling uses bits 7 to 4.
module tsc_sig_ctrl #(
	parameter int ADDR_W = 12
) (
	input  wire logic                 core_clk,       // Block clock, 250 MHz.
	input  wire logic                 arst_n,         // Asynchronous reset, active low.
	input  wire logic [ADDR_W-1:0]    s_axi_awaddr,   // Write address.
	input  wire logic                 s_axi_awvalid,  // Write address valid.
	output logic                      s_axi_awready,  // Write address ready.
	input  wire logic [31:0]          s_axi_wdata,    // Write data.
	input  wire logic [3:0]           s_axi_wstrb,    // Write byte strobes.
	input  wire logic                 s_axi_wvalid,   // Write data valid.
	output logic                      s_axi_wready,   // Write data ready.
	output logic [1:0]                s_axi_bresp,    // Write response.
	output logic                      s_axi_bvalid,   // Write response valid.
	input  wire logic                 s_axi_bready,   // Write response ready.
	input  wire logic [ADDR_W-1:0]    s_axi_araddr,   // Read address.
	input  wire logic                 s_axi_arvalid,  // Read address valid.
	output logic                      s_axi_arready,  // Read address ready.
	output logic [31:0]               s_axi_rdata,    // Read data.
	output logic [1:0]                s_axi_rresp,    // Read response.
	output logic                      s_axi_rvalid,   // Read data valid.
	input  wire logic                 s_axi_rready,   // Read data ready.
	input  wire tsc_pkg::tsc_tx_in_t  tx_serial_pcm_in, // Transmit octet from the serial PCM input.
	input  wire logic [3:0]           tx_sig_in_pin,  // Signaling pin A,B,C,D, asynchronous.
	output tsc_pkg::tsc_tx_out_t      tx_out,         // Transmit octet with signaling inserted.
	input  wire tsc_pkg::tsc_rx_in_t  rx_in,          // Receive octet from the line.
	output tsc_pkg::tsc_rx_out_t      rx_out          // Receive octet after suppression, with routing.
);

	import tsc_pkg::*;

	generate
		if (ADDR_W < 12)
		begin : g_bad_addr
			$error("ADDR_W must be at least 12");
		end
	endgenerate

	// ============================================================
	// Register storage
	logic [7:0] tx_regs [TSC_SLOTS];
	logic [7:0] rx_regs [TSC_SLOTS];
	logic [7:0] tx_sig_interface_enable_reg;
	logic [7:0] rx_sig_link_select_reg;
	logic [7:0] next_if_ctrl;
	logic [7:0] next_link_sel;
	logic [TSC_SLOTS-1:0] tx_we;
	logic [TSC_SLOTS-1:0] rx_we;

	// ============================================================
	// AXI4-Lite write channel
	logic [9:0] aw_idx;
	logic       aw_full;
	logic       w_full;
	logic [7:0] w_byte;
	logic       w_strb0;
	logic       next_aw_full;
	logic       next_w_full;
	logic [9:0] next_aw_idx;
	logic [7:0] next_w_byte;
	logic       next_w_strb0;
	logic       next_awready;
	logic       next_wready;
	logic       next_bvalid;
	logic [1:0] next_bresp;
	logic       do_write;
	logic       wr_tx_hit;
	logic       wr_rx_hit;
	logic [9:0] wr_tx_off;
	logic [9:0] wr_rx_off;

	always_comb
	begin
		do_write     = aw_full & w_full & ~s_axi_bvalid;
		wr_tx_hit    = (aw_idx >= TSC_TX_SIG_FIRST) && (aw_idx <= TSC_TX_SIG_LAST); // R5
		wr_rx_hit    = (aw_idx >= TSC_RX_CHAN_FIRST) && (aw_idx <= TSC_RX_CHAN_LAST); // R8
		wr_tx_off    = aw_idx - TSC_TX_SIG_FIRST;
		wr_rx_off    = aw_idx - TSC_RX_CHAN_FIRST;
		next_aw_idx  = aw_idx;
		next_w_byte  = w_byte;
		next_w_strb0 = w_strb0;
		if (s_axi_awvalid && s_axi_awready)
			next_aw_idx = s_axi_awaddr[11:2];
		if (s_axi_wvalid && s_axi_wready)
		begin
			next_w_byte  = s_axi_wdata[7:0];
			next_w_strb0 = s_axi_wstrb[0];
		end
		next_aw_full = do_write ? 1'b0 : (aw_full | (s_axi_awvalid & s_axi_awready));
		next_w_full  = do_write ? 1'b0 : (w_full | (s_axi_wvalid & s_axi_wready));
		next_awready = ~next_aw_full;
		next_wready  = ~next_w_full;
		next_bvalid  = s_axi_bvalid & ~s_axi_bready;
		next_bresp   = s_axi_bresp;
		if (do_write)
		begin
			next_bvalid = 1'b1;
			next_bresp  = (wr_tx_hit || wr_rx_hit || aw_idx == TSC_TX_IF_CTRL || aw_idx == TSC_RX_SIG_LINK)
				? TSC_RESP_OK : TSC_RESP_ERR;
		end
		for (int i = 0; i < TSC_SLOTS; i++)
		begin
			tx_we[i] = do_write & w_strb0 & wr_tx_hit & (wr_tx_off[4:0] == 5'(i));
			rx_we[i] = do_write & w_strb0 & wr_rx_hit & (wr_rx_off[4:0] == 5'(i));
		end
		next_if_ctrl  = (do_write && w_strb0 && aw_idx == TSC_TX_IF_CTRL) ? w_byte : tx_sig_interface_enable_reg;
		next_link_sel = (do_write && w_strb0 && aw_idx == TSC_RX_SIG_LINK) ? w_byte : rx_sig_link_select_reg;
	end

	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			aw_idx                      <= 10'h000;
			aw_full                     <= 1'b0;
			w_full                      <= 1'b0;
			w_byte                      <= 8'h00;
			w_strb0                     <= 1'b0;
			s_axi_awready               <= 1'b1;
			s_axi_wready                <= 1'b1;
			s_axi_bvalid                <= 1'b0;
			s_axi_bresp                 <= TSC_RESP_OK;
			tx_sig_interface_enable_reg <= TSC_CTRL_RST;
			rx_sig_link_select_reg      <= TSC_CTRL_RST;
		end
		else
		begin
			aw_idx                      <= next_aw_idx;
			aw_full                     <= next_aw_full;
			w_full                      <= next_w_full;
			w_byte                      <= next_w_byte;
			w_strb0                     <= next_w_strb0;
			s_axi_awready               <= next_awready;
			s_axi_wready                <= next_wready;
			s_axi_bvalid                <= next_bvalid;
			s_axi_bresp                 <= next_bresp;
			tx_sig_interface_enable_reg <= next_if_ctrl;
			rx_sig_link_select_reg      <= next_link_sel;
		end
	end

	// ============================================================
	// Per-timeslot register banks
	genvar g;
	generate
		for (g = 0; g < TSC_SLOTS; g++)
		begin : g_slot
			localparam logic [7:0] TX_RST = (g == 0) ? TSC_TX_RST_SLOT0 :
				(g == 16) ? TSC_TX_RST_SLOT16 : TSC_TX_RST_OTHER; // R4
			tsc_slot_reg #(.RST_VAL(TX_RST)) u_tx (
				.core_clk (core_clk),
				.arst_n   (arst_n),
				.wr_en    (tx_we[g]),
				.wr_data  (w_byte),
				.value    (tx_regs[g])
			);
			tsc_slot_reg #(.RST_VAL(TSC_RX_RST)) u_rx ( // R8
				.core_clk (core_clk),
				.arst_n   (arst_n),
				.wr_en    (rx_we[g]),
				.wr_data  (w_byte),
				.value    (rx_regs[g])
			);
		end
	endgenerate

	// ============================================================
	// AXI4-Lite read channel
	logic [9:0]  rd_idx;
	logic [9:0]  rd_tx_off;
	logic [9:0]  rd_rx_off;
	logic        next_rvalid;
	logic        next_arready;
	logic [31:0] next_rdata;
	logic [1:0]  next_rresp;

	always_comb
	begin
		rd_idx       = s_axi_araddr[11:2];
		rd_tx_off    = rd_idx - TSC_TX_SIG_FIRST;
		rd_rx_off    = rd_idx - TSC_RX_CHAN_FIRST;
		next_rvalid  = s_axi_rvalid & ~s_axi_rready;
		next_rdata   = s_axi_rdata;
		next_rresp   = s_axi_rresp;
		if (s_axi_arvalid && s_axi_arready)
		begin
			next_rvalid = 1'b1;
			next_rresp  = TSC_RESP_OK;
			next_rdata  = 32'h0000_0000;
			if ((rd_idx >= TSC_TX_SIG_FIRST) && (rd_idx <= TSC_TX_SIG_LAST))
				next_rdata[7:0] = tx_regs[rd_tx_off[4:0]];
			else if ((rd_idx >= TSC_RX_CHAN_FIRST) && (rd_idx <= TSC_RX_CHAN_LAST))
				next_rdata[7:0] = rx_regs[rd_rx_off[4:0]];
			else if (rd_idx == TSC_TX_IF_CTRL)
				next_rdata[7:0] = tx_sig_interface_enable_reg;
			else if (rd_idx == TSC_RX_SIG_LINK)
				next_rdata[7:0] = rx_sig_link_select_reg;
			else
				next_rresp = TSC_RESP_ERR;
		end
		next_arready = ~next_rvalid;
	end

	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= TSC_RESP_OK;
		end
		else
		begin
			s_axi_rvalid  <= next_rvalid;
			s_axi_arready <= next_arready;
			s_axi_rdata   <= next_rdata;
			s_axi_rresp   <= next_rresp;
		end
	end

	// ============================================================
	// Signaling pin synchroniser
	logic [3:0] pin_s1;
	logic [3:0] pin_s2;
	logic [3:0] pin_s3;
	logic [3:0] pin_abcd;
	logic [3:0] next_pin_abcd;

	always_comb
	begin
		next_pin_abcd = pin_abcd;
		for (int i = 0; i < 4; i++)
			if (pin_s2[i] == pin_s3[i])
				next_pin_abcd[i] = pin_s3[i];
	end

	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			pin_s1   <= 4'h0;
			pin_s2   <= 4'h0;
			pin_s3   <= 4'h0;
			pin_abcd <= 4'h0;
		end
		else
		begin
			pin_s1   <= tx_sig_in_pin;
			pin_s2   <= pin_s1;
			pin_s3   <= pin_s2;
			pin_abcd <= next_pin_abcd;
		end
	end

	// ============================================================
	// Transmit signaling insertion
	logic [7:0]  tx_cur;
	logic [1:0]  tx_sig_source_sel;
	logic        tx_rob;
	logic        tx_sig_interface_enable;
	logic        tx_reg_bit;
	logic        tx_pin_bit;
	tsc_tx_out_t next_tx_out;

	always_comb
	begin
		tx_cur                  = (tx_serial_pcm_in.slot < 5'(TSC_SLOTS)) ? tx_regs[tx_serial_pcm_in.slot] : 8'h00;
		tx_sig_source_sel       = tx_cur[TSC_SRC_LSB +: 2];
		tx_rob                  = tx_cur[TSC_ROB_EN_POS] & tx_serial_pcm_in.sig_frame;
		tx_sig_interface_enable = tx_sig_interface_enable_reg[TSC_IF_EN_POS];
		tx_reg_bit              = tx_cur[3'(TSC_SIG_A_POS) - {1'b0, tx_serial_pcm_in.sig_phase}]; // R14
		tx_pin_bit              = pin_abcd[2'd3 - tx_serial_pcm_in.sig_phase];
		next_tx_out.valid       = tx_serial_pcm_in.valid;
		next_tx_out.octet       = tx_serial_pcm_in.octet; // R1
		if (tx_rob && tx_sig_source_sel == TSC_SRC_REG)
			next_tx_out.octet[0] = tx_reg_bit; // R2 R13
		else if (tx_rob && tx_sig_source_sel == TSC_SRC_PIN && tx_sig_interface_enable)
			next_tx_out.octet[0] = tx_pin_bit; // R3
	end

	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
			tx_out <= '0;
		else
			tx_out <= next_tx_out;
	end

	// ============================================================
	// Receive routing and zero code suppression
	logic [7:0]  rx_cur;
	logic [1:0]  rx_link_ctrl_sel;
	logic [1:0]  rx_zero_suppr_sel;
	logic        rx_zero;
	tsc_rx_out_t next_rx_out;

	always_comb
	begin
		rx_cur              = (rx_in.slot < 5'(TSC_SLOTS)) ? rx_regs[rx_in.slot] : 8'h00;
		rx_link_ctrl_sel    = rx_cur[TSC_LINK_SEL_LSB +: 2];
		rx_zero_suppr_sel   = rx_cur[TSC_ZERO_SEL_LSB +: 2];
		rx_zero             = (rx_in.octet == 8'h00);
		next_rx_out.valid   = rx_in.valid;
		next_rx_out.octet   = rx_in.octet;
		next_rx_out.ctrl_sel = 3'h0;
		next_rx_out.alt_src = 1'b0;
		next_rx_out.de_src  = 2'h0;
		unique case (rx_link_ctrl_sel)
			TSC_LINK_C1:  next_rx_out.ctrl_sel = 3'h1; // R6
			TSC_LINK_C2:  next_rx_out.ctrl_sel = 3'h2; // R6
			TSC_LINK_C3:  next_rx_out.ctrl_sel = 3'h4; // R6
			TSC_LINK_ALT:
			begin
				next_rx_out.alt_src = 1'b1; // R7
				next_rx_out.de_src  = rx_sig_link_select_reg[TSC_DE_SRC_LSB +: 2]; // R7
			end
		endcase
		unique case (rx_zero_suppr_sel)
			TSC_ZS_NONE: next_rx_out.octet = rx_in.octet; // R9
			TSC_ZS_BIT7: next_rx_out.octet = rx_zero ? TSC_BIT7_MASK : rx_in.octet; // R10
			TSC_ZS_B8B7:
			begin
				if (rx_zero && !rx_in.sig_frame)
					next_rx_out.octet = TSC_BIT8_MASK; // R11
				else if (rx_zero && !rx_in.sig_bit)
					next_rx_out.octet = TSC_BIT7_MASK; // R11
			end
			TSC_ZS_DDS:  next_rx_out.octet = rx_zero ? TSC_DDS_CODE : rx_in.octet; // R12
		endcase
	end

	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
			rx_out <= '0;
		else
			rx_out <= next_rx_out;
	end

	// ============================================================
	// Assertions
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!arst_n);

	sequence s_write_ready;
		aw_full && w_full && !s_axi_bvalid;
	endsequence

	a_tx_pcm_pass: assert property ( // R1
		(tx_serial_pcm_in.valid && tx_sig_source_sel != TSC_SRC_REG && tx_sig_source_sel != TSC_SRC_PIN)
		|=> tx_out.octet == $past(tx_serial_pcm_in.octet))
		else $error("PCM signaling source altered the octet");

	a_tx_reg_insert: assert property ( // R2
		(tx_serial_pcm_in.valid && tx_rob && tx_sig_source_sel == TSC_SRC_REG)
		|=> tx_out.octet[0] == $past(tx_reg_bit) && tx_out.octet[7:1] == $past(tx_serial_pcm_in.octet[7:1]))
		else $error("Register signaling bit not inserted");

	a_tx_pin_insert: assert property ( // R3
		(tx_rob && tx_sig_source_sel == TSC_SRC_PIN)
		|=> tx_out.octet[0] == ($past(tx_sig_interface_enable) ? $past(tx_pin_bit) : $past(tx_serial_pcm_in.octet[0])))
		else $error("Pin signaling selection wrong");

	a_wr_resp_bound: assert property ( // Write answered one cycle after the request is complete.
		s_write_ready |=> s_axi_bvalid && s_axi_awready && s_axi_wready)
		else $error("Write response missing after write");

	a_rx_ctrl_route: assert property ( // R6
		(rx_link_ctrl_sel == TSC_LINK_C3) |=> rx_out.ctrl_sel == 3'h4 && !rx_out.alt_src)
		else $error("Link controller 3 not selected");

	a_rx_alt_source: assert property ( // R7
		(rx_link_ctrl_sel == TSC_LINK_ALT)
		|=> rx_out.alt_src && rx_out.ctrl_sel == 3'h0 && rx_out.de_src == $past(rx_sig_link_select_reg[1:0]))
		else $error("D/E source select not used");

	a_rx_no_supp: assert property ( // R9
		(rx_zero_suppr_sel == TSC_ZS_NONE) |=> rx_out.octet == $past(rx_in.octet))
		else $error("Octet changed without suppression");

	a_rx_bit_stuff: assert property ( // R10
		(rx_zero_suppr_sel == TSC_ZS_BIT7 && rx_zero) |=> rx_out.octet == 8'h02)
		else $error("Bit 7 not stuffed");

	a_rx_sig_frame: assert property ( // R11
		(rx_zero_suppr_sel == TSC_ZS_B8B7 && rx_zero && rx_in.sig_frame && rx_in.sig_bit) |=> rx_out.octet == 8'h00)
		else $error("Signaling frame stuffed with signaling bit set");

	a_rx_dds_code: assert property ( // R12
		(rx_zero_suppr_sel == TSC_ZS_DDS && rx_zero) |=> rx_out.octet == 8'h98)
		else $error("Data service code not substituted");

endmodule : tsc_sig_ctrl

// ### tsc_host_model.sv
// Purpose: Host processor model that programs the block over AXI4-Lite.
// Assumes: One write and one read at most under way; byte address is four times the index.
// Notes:   Waits for every answer without its own limit; the bench bounds the run.
module tsc_host_model (
	input  wire logic        core_clk, // Clock.
	output logic      [11:0] awaddr,   // Write address.
	output logic             awvalid,  // Write address valid.
	input  wire logic        awready,  // Write address ready.
	output logic      [31:0] wdata,    // Write data.
	output logic      [3:0]  wstrb,    // Write strobes.
	output logic             wvalid,   // Write data valid.
	input  wire logic        wready,   // Write data ready.
	input  wire logic [1:0]  bresp,    // Write response.
	input  wire logic        bvalid,   // Write response valid.
	output logic             bready,   // Write response ready.
	output logic      [11:0] araddr,   // Read address.
	output logic             arvalid,  // Read address valid.
	input  wire logic        arready,  // Read address ready.
	input  wire logic [31:0] rdata,    // Read data.
	input  wire logic [1:0]  rresp,    // Read response.
	input  wire logic        rvalid,   // Read data valid.
	output logic             rready    // Read data ready.
);
	timeunit 1ns;
	timeprecision 1ps;

	initial
	begin
		{awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
		{araddr, arvalid, rready} = '0;
	end

	// ============================================================
	// Bus tasks
	// Each channel drops its valid only at the edge that takes it.
	task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge core_clk);
		awaddr  <= a;
		wdata   <= d;
		wstrb   <= 4'hF;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		do
		begin
			@(posedge core_clk);
			if (awvalid && awready)
				awvalid <= 1'b0;
			if (wvalid && wready)
				wvalid <= 1'b0;
		end
		while (!bvalid);
		bready <= 1'b0;
		r = bresp;
	endtask : wr

	task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge core_clk);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		do
		begin
			@(posedge core_clk);
			if (arvalid && arready)
				arvalid <= 1'b0;
		end
		while (!rvalid);
		rready <= 1'b0;
		d = rdata;
		r = rresp;
	endtask : rd

endmodule : tsc_host_model

// ### tb_top.sv
// Purpose: Self-checking bench for per-timeslot signaling and receive control.
// Assumes: Registers are reached through the host model.
// Notes:   The signaling pin gets six cycles to pass its synchroniser.
module tb_top;
	import tsc_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;

	// ============================================================
	// Signals
	localparam logic [7:0] ZEXP [4] = '{8'h00, 8'h02, 8'h01, 8'h98};
	logic        core_clk = 1'b0;
	logic        arst_n   = 1'b0;
	logic [11:0] awaddr, araddr;
	logic        awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic [31:0] wdata, rdata, d;
	logic [3:0]  wstrb, pin;
	logic [1:0]  bresp, rresp, r;
	tsc_tx_in_t  tx_pcm;
	tsc_tx_out_t tx_out;
	tsc_rx_in_t  rx_in;
	tsc_rx_out_t rx_out, q;
	int          err_count   = 0;
	int          check_count = 0;
	int          cyc         = 0;

	always #2 core_clk = ~core_clk;

	tsc_host_model host (.core_clk(core_clk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
		.bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
		.rresp(rresp), .rvalid(rvalid), .rready(rready));

	tsc_sig_ctrl #(.ADDR_W(12)) DUT (.core_clk(core_clk), .arst_n(arst_n), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.tx_serial_pcm_in(tx_pcm), .tx_sig_in_pin(pin), .tx_out(tx_out), .rx_in(rx_in), .rx_out(rx_out));

	always @(posedge core_clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 5000)
		begin
			err_count++;
			$display("Timeout at %0t", $time);
			results();
		end
	end

	// ============================================================
	// Tasks
	function automatic logic [11:0] ba(input logic [9:0] idx);
		return {idx, 2'b00};
	endfunction : ba

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			err_count++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic results();
		$display("Checks %0d, mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : results

	task automatic tx_run(input logic sf, input logic [1:0] ph, input logic [7:0] o, output logic [7:0] g);
		@(posedge core_clk);
		tx_pcm <= '{1'b1, 5'h3, sf, ph, o};
		@(posedge core_clk);
		#1;
		g = tx_out.octet;
		chk(32'(tx_out.valid), 32'h1);
	endtask : tx_run

	task automatic rx_run(input logic sf, input logic sb, input logic [7:0] o);
		@(posedge core_clk);
		rx_in <= '{1'b1, 5'h7, sf, sb, o};
		@(posedge core_clk);
		#1;
		q = rx_out;
		chk(32'(q.valid), 32'h1);
	endtask : rx_run

	// Runs all four signaling phases on two octets whose last bits differ.
	task automatic sig_loop(input logic [3:0] s, input logic ins);
		logic [7:0] o;
		logic [7:0] g;
		for (int k = 0; k < 8; k++)
		begin
			o = (k < 4) ? 8'h5A : 8'hC3;
			tx_run(1'b1, 2'(k), o, g);
			chk(32'(g), {24'h0, o[7:1], ins ? s[3 - (k % 4)] : o[0]});
		end
	endtask : sig_loop

	// ============================================================
	// Tests
	initial
	begin
		tx_pcm = '0;
		rx_in  = '0;
		pin    = 4'h5;
		repeat (20) @(posedge core_clk);
		arst_n <= 1'b1;
		for (int i = 0; i < TSC_SLOTS; i++)
		begin
			host.rd(ba(TSC_TX_SIG_FIRST + 10'(i)), d, r);
			chk(d, {24'h0, (i == 0) ? 8'h01 : (i == 16) ? 8'hB3 : 8'hD0});
			chk(32'(r), 32'(TSC_RESP_OK));
			host.rd(ba(TSC_RX_CHAN_FIRST + 10'(i)), d, r);
			chk(d, 32'h0);
		end
		host.rd(ba(TSC_TX_SIG_LAST + 10'h1), d, r);
		chk(32'(r), 32'(TSC_RESP_ERR));
		host.rd(ba(TSC_RX_CHAN_LAST + 10'h1), d, r);
		chk(32'(r), 32'(TSC_RESP_ERR));
		$display("Test reset values done");
		for (int m = 0; m < 4; m++)
		begin
			host.wr(ba(TSC_TX_SIG_FIRST + 10'h3), 32'(8'hA4 + 8'(m)), r);
			chk(32'(r), 32'(TSC_RESP_OK));
			sig_loop(4'hA, m == 1);
		end
		host.wr(ba(TSC_TX_IF_CTRL), 32'h1, r);
		chk(32'(r), 32'(TSC_RESP_OK));
		host.wr(ba(TSC_TX_SIG_FIRST + 10'h3), 32'hA6, r);
		repeat (6) @(posedge core_clk);
		sig_loop(4'h5, 1'b1);
		host.wr(ba(TSC_TX_SIG_FIRST + 10'h3), 32'hA1, r);
		sig_loop(4'hA, 1'b0);
		host.rd(ba(TSC_TX_SIG_FIRST + 10'h3), d, r);
		chk(d, 32'hA1);
		$display("Test transmit signaling done");
		host.wr(ba(TSC_RX_SIG_LINK), 32'h2, r);
		for (int k = 0; k < 4; k++)
			for (int z = 0; z < 4; z++)
			begin
				host.wr(ba(TSC_RX_CHAN_FIRST + 10'h7), 32'({2'(k), 2'(z), 4'h0}), r);
				rx_run(1'b0, 1'b0, 8'h00);
				chk(32'(q.octet), 32'(ZEXP[z]));
				chk(32'(q.alt_src), 32'(k == 2));
				if (k == 2)
					chk(32'(q.de_src), 32'h2);
				else
					chk(32'(q.ctrl_sel), (k == 0) ? 32'h1 : (k == 1) ? 32'h2 : 32'h4);
				rx_run(1'b0, 1'b0, 8'h40);
				chk(32'(q.octet), 32'h40);
			end
		host.wr(ba(TSC_RX_CHAN_FIRST + 10'h7), 32'h20, r);
		rx_run(1'b1, 1'b0, 8'h00);
		chk(32'(q.octet), 32'h02);
		rx_run(1'b1, 1'b1, 8'h00);
		chk(32'(q.octet), 32'h00);
		host.rd(ba(TSC_RX_CHAN_FIRST + 10'h7), d, r);
		chk(d, 32'h20);
		host.wr(ba(TSC_RX_CHAN_LAST + 10'h1), 32'h55, r);
		chk(32'(r), 32'(TSC_RESP_ERR));
		$display("Test receive control done");
		results();
	end

endmodule : tb_top
